//--- test/repeater_lane_config_regs_tb.sv
// self-checking bench for the lane configuration registers
`timescale 1ns/1ps
`default_nettype none
module repeater_lane_config_regs_tb;
   import rlc_pkg::*;
   // short probe counts keep the run small
   localparam int PER = 8;
   localparam int ATT = 3;
   logic clk = 1'b0, rst_n = 1'b0, term5 = 1'b0, sd_ovr = 1'b1, rx_ovr = 1'b1, far = 1'b0;
   logic [3:0] sd_strap = 4'h0;
   logic [1:0] rx_strap = 2'h0;
   rlc_reg_req_t req;
   logic [7:0] rdata, boost;
   logic rvalid, term6, probe;
   logic [2:0] deemph;
   logic [1:0] sd_a, sd_d;
   logic [7:0] shadow [0:255];
   int err_total = 0, n_compared = 0, n_probe = 0, seed_val;

   rlc_lane_regs #(.P_PERIOD_CYCLES(PER), .P_ATTEMPTS(ATT)) uut (.i_clock(clk), .i_rst_n(rst_n),
      .i_req(req), .i_lane5_terminated(term5), .i_sigdet_override(sd_ovr),
      .i_sigdet_strap(sd_strap), .i_far_receiver_detect_override(rx_ovr), .i_far_receiver_detect_strap(rx_strap),
      .i_far_present(far), .o_rdata(rdata), .o_rvalid(rvalid), .o_lane5_deemph(deemph),
      .o_sigdet_assert_sel(sd_a), .o_sigdet_deassert_sel(sd_d), .o_lane6_boost(boost),
      .o_lane6_term_50(term6), .o_lane6_probe(probe));
   rlc_host_model host (.i_clock(clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));

   initial begin
      forever #2 clk = ~clk;
   end

   // probe pulses are one cycle wide, so count them at each rising edge
   always @(posedge clk) begin
      if (probe === 1'b1) n_probe++;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
      host.write_reg(a, d, raw);
      shadow[a] = host.legal_bits(a, d);
   endtask

   // status bit comes from the pin, never from the stored byte
   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] d, e;
      logic v;
      host.read_reg(a, d, v);
      e = shadow[a];
      if (a == ADDR_DEEMPH) e[7] = term5;
      check({7'h0, v}, 8'h01);
      check(d, e);
   endtask

   // back-to-back write and read; not for the status register
   task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic v;
      host.write_read(a, d, q, v);
      shadow[a] = host.legal_bits(a, d);
      check({7'h0, v}, 8'h01);
      check(q, shadow[a]);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic outs_chk();
      cyc(2);
      check({5'h0, deemph}, {5'h0, shadow[ADDR_DEEMPH][2:0]});
      check(boost, shadow[ADDR_BOOST]);
      check({6'h0, sd_a}, {6'h0, shadow[ADDR_SDTH][3:2]});
      check({6'h0, sd_d}, {6'h0, shadow[ADDR_SDTH][1:0]});
   endtask

   task automatic wait_term();
      int k;
      for (k = 0; k < PER + 4 && term6 !== 1'b1; k++) cyc(1);
   endtask

   // hang guard: a stuck run still reaches the verdict
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end

   initial begin
      seed_val = $urandom(32'h149d);
      for (int i = 0; i < 256; i++) shadow[i] = 8'h00;
      shadow[ADDR_DEEMPH] = DEEMPH_RESET;
      shadow[ADDR_BOOST] = BOOST_RESET;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      // reset values, reserved and unmapped places
      outs_chk();
      check({7'h0, term6}, 8'h00);
      for (int a = 8'h34; a <= 8'h3b; a++) rd_chk(a[7:0]);
      $display("test reset done");
      // status bit and dropped reserved writes
      term5 = 1'b1;
      rd_chk(ADDR_DEEMPH);
      for (int a = 8'h35; a <= 8'h3b; a++) begin
         if (a != 8'h39) wr(a[7:0], 8'hff, 1'b1);
         rd_chk(a[7:0]);
      end
      term5 = 1'b0;
      rd_chk(ADDR_DEEMPH);
      $display("test status done");
      // every de-emphasis code, then random traffic
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_DEEMPH, c[7:0], 1'b0);
         outs_chk();
      end
      for (int i = 0; i < 24; i++) begin
         wr(8'h35 + 8'($urandom % 6), 8'($urandom), 1'b0);
         outs_chk();
         rd_chk(8'h35 + 8'($urandom % 6));
      end
      // write then read back in adjacent cycles
      for (int i = 0; i < 4; i++) wr_rd_chk(ADDR_BOOST, 8'($urandom));
      wr_rd_chk(ADDR_SDTH, 8'($urandom));
      outs_chk();
      $display("test random done");
      // strap governs thresholds without override
      for (int i = 0; i < 4; i++) begin
         sd_ovr = 1'b0;
         sd_strap = 4'($urandom);
         cyc(2);
         check({4'h0, sd_a, sd_d}, {4'h0, sd_strap});
         sd_ovr = 1'b1;
         outs_chk();
      end
      $display("test threshold override done");
      // strap governs detect mode without override
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h0c, 1'b0);
      rx_ovr = 1'b0;
      rx_strap = FAR_RECEIVER_DETECT_HIZ;
      cyc(3);
      check({7'h0, term6}, 8'h00);
      rx_strap = FAR_RECEIVER_DETECT_FORCE_50;
      cyc(3);
      check({7'h0, term6}, 8'h01);
      rx_strap = FAR_RECEIVER_DETECT_HIZ;
      rx_ovr = 1'b1;
      cyc(3);
      check({7'h0, term6}, 8'h01);
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h00, 1'b0);
      cyc(3);
      check({7'h0, term6}, 8'h00);
      $display("test detect override done");
      // endless search keeps probing past the attempt limit
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h08, 1'b0);
      n_probe = 0;
      cyc(5 * PER);
      check({7'h0, n_probe > ATT}, 8'h01);
      check({7'h0, term6}, 8'h00);
      far = 1'b1;
      wait_term();
      check({6'h0, term6, probe}, 8'h03);
      far = 1'b0;
      $display("test endless search done");
      // limited search stops after the attempt count
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h00, 1'b0);
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h04, 1'b0);
      n_probe = 0;
      cyc(7 * PER);
      check(8'(n_probe), 8'(ATT));
      check({7'h0, term6}, 8'h00);
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h00, 1'b0);
      far = 1'b1;
      wr(ADDR_FAR_RECEIVER_DETECT, 8'h04, 1'b0);
      wait_term();
      check({6'h0, term6, probe}, 8'h03);
      $display("test limited search done");
      print_verdict();
   end
endmodule
`default_nettype wire

//--- test/rlc_host_model.sv
// register host model driving the lane register port
`timescale 1ns/1ps
`default_nettype none
module rlc_host_model (
   input wire logic i_clock,
   output rlc_pkg::rlc_reg_req_t o_req,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid
);
   import rlc_pkg::*;

   // only defined bits may carry ones from a well behaved host
   function automatic logic [7:0] legal_bits(input logic [7:0] a, input logic [7:0] d);
      case (a)
         ADDR_DEEMPH: legal_bits = d & 8'h07;
         ADDR_SDTH: legal_bits = d & 8'h0f;
         ADDR_FAR_RECEIVER_DETECT: legal_bits = d & 8'h0c;
         ADDR_BOOST: legal_bits = d;
         default: legal_bits = 8'h00;
      endcase
   endfunction

   initial o_req = '0;

   // raw set only by scenarios that break the host rule on purpose
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input bit raw);
      @(negedge i_clock);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: raw ? d : legal_bits(a, d)};
      @(negedge i_clock);
      o_req = '0;
   endtask

   // write then read the same place in the next cycle, no idle cycle between
   task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
      @(negedge i_clock);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: legal_bits(a, d)};
      @(negedge i_clock);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_clock);
      q = i_rdata;
      v = i_rvalid;
      o_req = '0;
   endtask

   // answer lands half a cycle after the strobe edge, taken at the next falling edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge i_clock);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_clock);
      d = i_rdata;
      v = i_rvalid;
      o_req = '0;
   endtask
endmodule
`default_nettype wire

//--- verilog/rlc_field.sv
// one read-write configuration field with its reset value
`timescale 1ns/1ps
`default_nettype none
module rlc_field #(
   parameter int P_WIDTH = 8,
   parameter logic [P_WIDTH-1:0] P_RESET = '0
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_write,
   input wire logic [P_WIDTH-1:0] i_wdata,
   output logic [P_WIDTH-1:0] o_value
);
   logic [P_WIDTH-1:0] value_reg;
   logic [P_WIDTH-1:0] value_next;

   // a write replaces the field, otherwise it holds
   assign value_next = i_write ? i_wdata : value_reg;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         value_reg <= P_RESET;
      end else begin
         value_reg <= value_next;
      end
   end

   assign o_value = value_reg;
endmodule
`default_nettype wire

//--- verilog/rlc_lane_regs.sv
// lane configuration and status registers with receive-detect control
`timescale 1ns/1ps
`default_nettype none

//Function
//- de-emphasis register bit 7 reads lane five input termination state
//- de-emphasis field resets to 010; eight codes from 0 to -12 dB
//- assert threshold bits 3:2 reset to 00, four level codes
//- de-assert threshold bits 1:0 reset to 00, four level codes
//- threshold fields act only when global override set, else strap governs
//- mode 01 probes every 12 ms, gives up after 50 attempts
//- mode 10 probes every 12 ms until detection, then terminates
//- mode field acts only when global override set, else strap governs
//- lane six boost register is eight bits, resets to 0x2f
module rlc_lane_regs
   import rlc_pkg::*;
#(
   parameter int P_PERIOD_CYCLES = rlc_pkg::PROBE_PERIOD_CYCLES,
   parameter int P_ATTEMPTS = rlc_pkg::PROBE_ATTEMPTS
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire rlc_pkg::rlc_reg_req_t i_req,
   input wire logic i_lane5_terminated,
   input wire logic i_sigdet_override,
   input wire logic [3:0] i_sigdet_strap,
   input wire logic i_far_receiver_detect_override,
   input wire logic [1:0] i_far_receiver_detect_strap,
   input wire logic i_far_present,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic [2:0] o_lane5_deemph,
   output logic [1:0] o_sigdet_assert_sel,
   output logic [1:0] o_sigdet_deassert_sel,
   output logic [7:0] o_lane6_boost,
   output logic o_lane6_term_50,
   output logic o_lane6_probe
);
   import rlc_pkg::*;

   // refuse probe settings that the sequencer counters cannot hold
   generate
      if (P_PERIOD_CYCLES < 2 || P_ATTEMPTS < 1) begin : g_bad_probe
         $error("probe period or attempt count out of range");
      end
   endgenerate

   logic [2:0] deemph_value;
   logic [3:0] sdth_value;
   logic [1:0] far_receiver_detect_value;
   logic [7:0] boost_value;
   logic [1:0] eff_mode;
   logic [3:0] sdth_eff;
   logic [3:0] sdth_reg;
   logic [7:0] rd_mux;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg;

   // address match shared by the write strobes and the read mux
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = a == target;
   endfunction

   // write strobes; reserved registers take no write
   wire wr_deemph = i_req.wr && hit(i_req.addr, ADDR_DEEMPH);
   wire wr_sdth = i_req.wr && hit(i_req.addr, ADDR_SDTH);
   wire wr_far_receiver_detect = i_req.wr && hit(i_req.addr, ADDR_FAR_RECEIVER_DETECT);
   wire wr_boost = i_req.wr && hit(i_req.addr, ADDR_BOOST);

   // reserved write bits are dropped, so a stray one cannot steer logic
   wire [2:0] wd_deemph = i_req.wdata[DEEMPH_LSB +: DEEMPH_W];
   wire [3:0] wd_sdth = i_req.wdata[0 +: SDTH_W];
   wire [1:0] wd_far_receiver_detect = i_req.wdata[FAR_RECEIVER_DETECT_LSB +: FAR_RECEIVER_DETECT_W];

   // output de-emphasis code, passed to the driver unchanged
   rlc_field #(
      .P_WIDTH(DEEMPH_W),
      .P_RESET(DEEMPH_RESET)
   ) u_deemph (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_write(wr_deemph),
      .i_wdata(wd_deemph),
      .o_value(deemph_value)
   );

   // signal detect assert and de-assert threshold pair
   rlc_field #(
      .P_WIDTH(SDTH_W),
      .P_RESET(SDTH_RESET)
   ) u_sdth (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_write(wr_sdth),
      .i_wdata(wd_sdth),
      .o_value(sdth_value)
   );

   // receive-detect mode code
   rlc_field #(
      .P_WIDTH(FAR_RECEIVER_DETECT_W),
      .P_RESET(FAR_RECEIVER_DETECT_RESET)
   ) u_far_receiver_detect (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_write(wr_far_receiver_detect),
      .i_wdata(wd_far_receiver_detect),
      .o_value(far_receiver_detect_value)
   );

   // input boost byte, decoded by the equalizer outside
   rlc_field #(
      .P_WIDTH(BOOST_W),
      .P_RESET(BOOST_RESET)
   ) u_boost (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_write(wr_boost),
      .i_wdata(i_req.wdata),
      .o_value(boost_value)
   );

   // global override picks register or strap
   assign sdth_eff = i_sigdet_override ? sdth_value : i_sigdet_strap;
   assign eff_mode = i_far_receiver_detect_override ? far_receiver_detect_value : i_far_receiver_detect_strap;

   // auto detect runs on the effective mode only
   rlc_rx_detect #(
      .P_PERIOD_CYCLES(P_PERIOD_CYCLES),
      .P_ATTEMPTS(P_ATTEMPTS)
   ) u_rx_detect (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_mode(eff_mode),
      .i_far_present(i_far_present),
      .o_term_50(o_lane6_term_50),
      .o_probe(o_lane6_probe)
   );

   // read mux: reserved bits and unmapped offsets read zero
   assign rd_mux =
      hit(i_req.addr, ADDR_DEEMPH) ? {i_lane5_terminated, 4'h0, deemph_value} :
      hit(i_req.addr, ADDR_SDTH) ? {4'h0, sdth_value} :
      hit(i_req.addr, ADDR_FAR_RECEIVER_DETECT) ? {4'h0, far_receiver_detect_value, 2'h0} :
      hit(i_req.addr, ADDR_BOOST) ? boost_value :
      8'h00;

   // read data holds until the next read
   assign rdata_next = i_req.rd ? rd_mux : rdata_reg;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         sdth_reg <= SDTH_RESET;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= i_req.rd;
         sdth_reg <= sdth_eff;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_rvalid = rvalid_reg;
   assign o_lane5_deemph = deemph_value;
   assign o_lane6_boost = boost_value;
   // thresholds registered so a strap glitch cannot reach the comparator raw
   assign o_sigdet_assert_sel = sdth_reg[SDTH_ASSERT_LSB +: 2];
   assign o_sigdet_deassert_sel = sdth_reg[SDTH_DEASSERT_LSB +: 2];

   // checks on the register slice
   property p_status_read;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == ADDR_DEEMPH) |=>
         (o_rvalid && o_rdata[STATUS_BIT] == $past(i_lane5_terminated));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status bit mismatch");

   property p_deemph_reset;
      @(posedge i_clock) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> (o_lane5_deemph == DEEMPH_RESET);
   endproperty
   a_deemph_reset: assert property (p_deemph_reset) else $error("de-emphasis reset wrong");

   property p_sdth_assert;
      @(posedge i_clock) disable iff (!i_rst_n)
      i_sigdet_override |=> (o_sigdet_assert_sel == $past(sdth_value[3:2]));
   endproperty
   a_sdth_assert: assert property (p_sdth_assert) else $error("assert threshold wrong");

   property p_sdth_deassert;
      @(posedge i_clock) disable iff (!i_rst_n)
      i_sigdet_override |=> (o_sigdet_deassert_sel == $past(sdth_value[1:0]));
   endproperty
   a_sdth_deassert: assert property (p_sdth_deassert) else $error("de-assert threshold wrong");

   property p_sdth_strap;
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_sigdet_override |=>
         ({o_sigdet_assert_sel, o_sigdet_deassert_sel} == $past(i_sigdet_strap));
   endproperty
   a_sdth_strap: assert property (p_sdth_strap) else $error("strap not followed");

   property p_force_hiz;
      @(posedge i_clock) disable iff (!i_rst_n)
      (eff_mode == FAR_RECEIVER_DETECT_HIZ) [*2] |-> !o_lane6_term_50;
   endproperty
   a_force_hiz: assert property (p_force_hiz) else $error("terminated in high-z mode");

   property p_force_50;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_far_receiver_detect_override && far_receiver_detect_value == FAR_RECEIVER_DETECT_FORCE_50) [*2] |-> o_lane6_term_50;
   endproperty
   a_force_50: assert property (p_force_50) else $error("forced termination missing");

   property p_far_receiver_detect_strap;
      @(posedge i_clock) disable iff (!i_rst_n)
      (!i_far_receiver_detect_override && i_far_receiver_detect_strap == FAR_RECEIVER_DETECT_FORCE_50) [*2] |-> o_lane6_term_50;
   endproperty
   a_far_receiver_detect_strap: assert property (p_far_receiver_detect_strap) else $error("mode strap not followed");

   property p_boost_reset;
      @(posedge i_clock) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> (o_lane6_boost == BOOST_RESET);
   endproperty
   a_boost_reset: assert property (p_boost_reset) else $error("boost reset wrong");

   property p_reserved_zero;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_req.rd && (i_req.addr == ADDR_RSVD_A || i_req.addr == ADDR_RSVD_B)) |=>
         (o_rdata == 8'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved reads nonzero");

   property p_deemph_rsvd_read;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == ADDR_DEEMPH) |=> (o_rdata[6:3] == 4'h0);
   endproperty
   a_deemph_rsvd_read: assert property (p_deemph_rsvd_read) else $error("de-emphasis spare bits set");

   property p_sdth_rsvd_read;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == ADDR_SDTH) |=> (o_rdata[7:4] == 4'h0);
   endproperty
   a_sdth_rsvd_read: assert property (p_sdth_rsvd_read) else $error("threshold spare bits set");

   property p_far_receiver_detect_rsvd_read;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == ADDR_FAR_RECEIVER_DETECT) |=> (o_rdata[7:4] == 4'h0 && o_rdata[1:0] == 2'h0);
   endproperty
   a_far_receiver_detect_rsvd_read: assert property (p_far_receiver_detect_rsvd_read) else $error("mode spare bits set");

   property p_rvalid_pulse;
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_req.rd |=> !o_rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a read");

   property p_rdata_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_req.rd |=> $stable(o_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

   property p_deemph_write;
      @(posedge i_clock) disable iff (!i_rst_n)
      wr_deemph |=> (o_lane5_deemph == $past(i_req.wdata[2:0]));
   endproperty
   a_deemph_write: assert property (p_deemph_write) else $error("de-emphasis write lost");

   property p_deemph_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      !wr_deemph |=> $stable(o_lane5_deemph);
   endproperty
   a_deemph_hold: assert property (p_deemph_hold) else $error("de-emphasis moved without a write");

   property p_boost_write;
      @(posedge i_clock) disable iff (!i_rst_n)
      wr_boost |=> (o_lane6_boost == $past(i_req.wdata));
   endproperty
   a_boost_write: assert property (p_boost_write) else $error("boost write lost");

   property p_boost_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      !wr_boost |=> $stable(o_lane6_boost);
   endproperty
   a_boost_hold: assert property (p_boost_hold) else $error("boost moved without a write");

   sequence s_boost_wr_rd;
      (i_req.wr && !i_req.rd && i_req.addr == ADDR_BOOST) ##1
      (i_req.rd && !i_req.wr && i_req.addr == ADDR_BOOST);
   endsequence

   property p_write_read;
      @(posedge i_clock) disable iff (!i_rst_n)
      s_boost_wr_rd |=> (o_rdata == $past(i_req.wdata, 2));
   endproperty
   a_write_read: assert property (p_write_read) else $error("read back differs");

   c_write_read: cover property (@(posedge i_clock) disable iff (!i_rst_n) s_boost_wr_rd);
   c_probe: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_lane6_probe);
   c_override: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      i_far_receiver_detect_override && far_receiver_detect_value == FAR_RECEIVER_DETECT_AUTO_FOREVER);
endmodule
`default_nettype wire

//--- verilog/rlc_pkg.sv
// constants and types of the repeater lane configuration slice
package rlc_pkg;

   // register byte offsets on the register port
   localparam logic [7:0] ADDR_DEEMPH = 8'h35;
   localparam logic [7:0] ADDR_SDTH = 8'h36;
   localparam logic [7:0] ADDR_RSVD_A = 8'h37;
   localparam logic [7:0] ADDR_RSVD_B = 8'h38;
   localparam logic [7:0] ADDR_FAR_RECEIVER_DETECT = 8'h39;
   localparam logic [7:0] ADDR_BOOST = 8'h3a;

   // field positions and widths
   localparam int STATUS_BIT = 7;
   localparam int DEEMPH_LSB = 0;
   localparam int DEEMPH_W = 3;
   localparam int SDTH_ASSERT_LSB = 2;
   localparam int SDTH_DEASSERT_LSB = 0;
   localparam int SDTH_W = 4;
   localparam int FAR_RECEIVER_DETECT_LSB = 2;
   localparam int FAR_RECEIVER_DETECT_W = 2;
   localparam int BOOST_W = 8;

   // values after reset
   localparam logic [2:0] DEEMPH_RESET = 3'h2;
   localparam logic [3:0] SDTH_RESET = 4'h0;
   localparam logic [1:0] FAR_RECEIVER_DETECT_RESET = 2'h0;
   localparam logic [7:0] BOOST_RESET = 8'h2f;

   // receive-detect mode codes
   localparam logic [1:0] FAR_RECEIVER_DETECT_HIZ = 2'h0;
   localparam logic [1:0] FAR_RECEIVER_DETECT_AUTO_LIMITED = 2'h1;
   localparam logic [1:0] FAR_RECEIVER_DETECT_AUTO_FOREVER = 2'h2;
   localparam logic [1:0] FAR_RECEIVER_DETECT_FORCE_50 = 2'h3;

   // probe timing
   localparam int CLOCK_KHZ = 250000;
   localparam int PROBE_PERIOD_MS = 12;
   localparam int PROBE_WINDOW_MS = 600;
   localparam int PROBE_PERIOD_CYCLES = PROBE_PERIOD_MS * CLOCK_KHZ;
   localparam int PROBE_ATTEMPTS = PROBE_WINDOW_MS / PROBE_PERIOD_MS;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rlc_reg_req_t;

   // auto-detect sequencer states
   typedef enum logic [3:0] {
      RD_IDLE = 4'h1,
      RD_SEARCH = 4'h2,
      RD_FOUND = 4'h4,
      RD_STOPPED = 4'h8
   } rlc_rd_state_t;

endpackage

//--- verilog/rlc_rx_detect.sv
// far receiver detect sequencer and input termination control
`timescale 1ns/1ps
`default_nettype none
module rlc_rx_detect
   import rlc_pkg::*;
#(
   parameter int P_PERIOD_CYCLES = PROBE_PERIOD_CYCLES,
   parameter int P_ATTEMPTS = PROBE_ATTEMPTS
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [1:0] i_mode,
   input wire logic i_far_present,
   output logic o_term_50,
   output logic o_probe
);
   localparam int TW = $clog2(P_PERIOD_CYCLES + 1);
   localparam int AW = $clog2(P_ATTEMPTS + 1);

   generate
      if (P_PERIOD_CYCLES < 2 || P_ATTEMPTS < 1) begin : g_bad
         $error("probe period or attempt count too small");
      end
   endgenerate

   rlc_rd_state_t state_reg, state_next;
   logic [1:0] mode_reg;
   logic [TW-1:0] timer_reg, timer_next;
   logic [AW-1:0] tries_reg, tries_next;
   logic term_reg, term_next, probe_reg, probe_next;
   logic changed, tick, is_auto, last_try;

   // a new mode restarts the sequence from idle
   assign changed = i_mode != mode_reg;
   assign is_auto = i_mode == FAR_RECEIVER_DETECT_AUTO_LIMITED || i_mode == FAR_RECEIVER_DETECT_AUTO_FOREVER;
   assign tick = state_reg == RD_SEARCH && timer_reg == TW'(P_PERIOD_CYCLES - 1);
   assign last_try = tries_reg == AW'(P_ATTEMPTS - 1);

   // sequencer: far end sampled on each probe instant
   always_comb begin
      state_next = state_reg;
      timer_next = '0;
      tries_next = tries_reg;
      unique case (state_reg)
         RD_IDLE: begin
            tries_next = '0;
            if (is_auto) begin
               state_next = RD_SEARCH;
            end
         end
         RD_SEARCH: begin
            timer_next = tick ? '0 : timer_reg + 1'b1;
            if (tick && i_far_present) begin
               state_next = RD_FOUND;
            end else if (tick) begin
               tries_next = tries_reg + 1'b1;
               if (i_mode == FAR_RECEIVER_DETECT_AUTO_LIMITED && last_try) begin
                  state_next = RD_STOPPED;
               end
            end
         end
         RD_FOUND: state_next = RD_FOUND;
         RD_STOPPED: state_next = RD_STOPPED;
         default: state_next = RD_IDLE;
      endcase
      if (changed) begin
         state_next = RD_IDLE;
         timer_next = '0;
         tries_next = '0;
      end
   end

   // termination follows the next state so forced codes act in one edge
   assign term_next = state_next == RD_FOUND ||
      (state_next == RD_IDLE && i_mode == FAR_RECEIVER_DETECT_FORCE_50);
   assign probe_next = tick && !changed;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= RD_IDLE;
         mode_reg <= FAR_RECEIVER_DETECT_RESET;
         timer_reg <= '0;
         tries_reg <= '0;
         term_reg <= 1'b0;
         probe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mode_reg <= i_mode;
         timer_reg <= timer_next;
         tries_reg <= tries_next;
         term_reg <= term_next;
         probe_reg <= probe_next;
      end
   end

   assign o_term_50 = term_reg;
   assign o_probe = probe_reg;

   property p_found_term;
      @(posedge i_clock) disable iff (!i_rst_n)
      (tick && i_far_present && !changed) |=> (o_term_50 && o_probe);
   endproperty
   a_found_term: assert property (p_found_term) else $error("detection did not terminate");

   property p_stop_limit;
      @(posedge i_clock) disable iff (!i_rst_n)
      (state_reg == RD_STOPPED) |-> (tries_reg == AW'(P_ATTEMPTS) && !o_term_50);
   endproperty
   a_stop_limit: assert property (p_stop_limit) else $error("stopped at wrong attempt count");

   property p_search_hiz;
      @(posedge i_clock) disable iff (!i_rst_n)
      (state_reg == RD_SEARCH) |-> !o_term_50;
   endproperty
   a_search_hiz: assert property (p_search_hiz) else $error("terminated before detection");

   c_found: cover property (@(posedge i_clock) disable iff (!i_rst_n) state_reg == RD_FOUND);
   c_stopped: cover property (@(posedge i_clock) disable iff (!i_rst_n) state_reg == RD_STOPPED);
endmodule
`default_nettype wire
